// *** hw/eamc_consts.svh ***
// offsets, field positions, reset values and thresholds of the
// accumulation mode block; included by the top module and the bench
`ifndef EAMC_CONSTS_SVH
`define EAMC_CONSTS_SVH
// register indices; byte address is four times the index
`define EAMC_IDX_ACCUMULATION_MODE_CONFIG 18'h0e701
`define EAMC_IDX_LCYC 18'h0e702
`define EAMC_IDX_TERMS 18'h0e710
`define EAMC_IDX_LCCNT 18'h0e711
`define EAMC_IDX_FLAGS 18'h0e500
`define EAMC_IDX_ENERGY 18'h0e400
`define EAMC_NUM_ENERGY 5'h0f
// reset values and register masks
`define EAMC_ACCM_RST 8'h00
`define EAMC_LCYC_RST 8'h78
`define EAMC_LCYC_MASK 8'h7f
`define EAMC_TERMS_RST 3'h7
`define EAMC_LCCNT_RST 16'h0064
`define EAMC_FLAG_MASK 16'h1dc0
// field positions
`define EAMC_REACTIVE_ACCUM_MODE_LO 2
`define EAMC_CONNECTION_SELECT_LO 4
`define EAMC_REVAP_BIT 6
`define EAMC_REVRP_BIT 7
`define EAMC_ACTIVE_LINE_CYCLE_EN_BIT 0
`define EAMC_REACTIVE_LINE_CYCLE_EN_BIT 1
`define EAMC_LVA_BIT 2
`define EAMC_ZX_LO 3
`define EAMC_READ_CLEAR_EN_BIT 6
`define EAMC_FLAG_REVAP_LO 6
`define EAMC_FLAG_REVRP_LO 10
// energy per frequency output pulse
`define EAMC_CF_THRESH 35'h000100000
`endif

// *** hw/eamc_pkg.sv ***
// types shared by the accumulation mode block
// assumes nothing of its surroundings
package eamc_pkg;
  // wiring configuration, in field order 00..11
  typedef enum logic [1:0] {EAMC_WYE3, EAMC_DELTA3, EAMC_WYE2, EAMC_DELTA4} eamc_connection_select_t;
  // reactive accumulation toward the frequency outputs
  typedef enum logic [1:0] {EAMC_VAR_SIGNED, EAMC_VAR_RSVD, EAMC_VAR_BY_ACT,
                            EAMC_VAR_ABS} eamc_reactive_accum_mode_t;
endpackage

// *** hw/eamc_wiring.sv ***
// phase b voltage derivation for the four wiring configurations
// assumes samples and rms values are aligned in the same cycle
`timescale 1ns/10ps
`default_nettype none
module eamc_wiring #(
  parameter int VW = 16
)(
  input wire eamc_pkg::eamc_connection_select_t connection_select_i,
  input wire logic [VW-1:0] va_i,
  input wire logic [VW-1:0] vb_i,
  input wire logic [VW-1:0] vc_i,
  input wire logic [VW-1:0] va_rms_i,
  input wire logic [VW-1:0] vb_rms_i,
  input wire logic [VW-1:0] line_ac_rms_i,
  input wire logic [VW-1:0] wye2_b_rms_i,
  output logic [VW:0] vb_eff_o,
  output logic [VW-1:0] vb_rms_eff_o,
  output logic [VW-1:0] vb_rms_reg_o
);
  import eamc_pkg::*;
  logic signed [VW:0] sa, sb, sc;
  // one extra bit so that negation and a-c never wrap; -a-c wraps only when a and c are both most negative
  always_comb
  begin
    sa = $signed({va_i[VW-1], va_i});
    sb = $signed({vb_i[VW-1], vb_i});
    sc = $signed({vc_i[VW-1], vc_i});
    unique case (connection_select_i)
      EAMC_WYE3:
      begin
        vb_eff_o = sb;
        vb_rms_eff_o = vb_rms_i;
        vb_rms_reg_o = vb_rms_i;
      end
      EAMC_DELTA3:
      begin
        vb_eff_o = sa - sc;
        vb_rms_eff_o = line_ac_rms_i;
        vb_rms_reg_o = line_ac_rms_i;
      end
      EAMC_WYE2:
      begin
        vb_eff_o = -sa - sc;
        vb_rms_eff_o = wye2_b_rms_i;
        vb_rms_reg_o = vb_rms_i;
      end
      EAMC_DELTA4:
      begin
        vb_eff_o = -sa;
        vb_rms_eff_o = va_rms_i; // rms of -va equals rms of va
        vb_rms_reg_o = vb_rms_i;
      end
    endcase
  end
endmodule // eamc_wiring
`default_nettype wire

// *** hw/eamc_accum.sv ***
// one energy accumulation register with regular and line-cycle modes
// assumes interval_end_i is a one-cycle pulse from the zero-cross counter
`timescale 1ns/10ps
`default_nettype none
module eamc_accum #(
  parameter int EW = 32
)(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic sample_i,
  input wire logic [EW-1:0] power_i,
  input wire logic line_mode_i,
  input wire logic interval_end_i,
  input wire logic clear_i,
  input wire logic [EW-1:0] clear_val_i,
  output logic [EW-1:0] value_o
);
  typedef struct packed {
    logic [EW-1:0] value;
    logic [EW-1:0] run;
  } eamc_acc_t;
  eamc_acc_t s, n;
  logic [EW-1:0] add, base;

  // clear subtracts what the read returned, so a sample in the same
  // cycle or since the setup phase is never lost
  always_comb
  begin
    n = s;
    add = sample_i ? power_i : '0;
    base = clear_i ? s.value - clear_val_i : s.value;
    if (line_mode_i)
    begin
      n.run = interval_end_i ? '0 : s.run + add;
      n.value = interval_end_i ? s.run + add : base;
    end
    else
    begin
      n.run = '0;
      n.value = base + add;
    end
  end

  // state register
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      s <= '0;
    else
      s <= n;
  end
  assign value_o = s.value;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  AST_REG_SUM: assert property (!line_mode_i && !clear_i |=>
    s.value == $past(s.value) + $past(add))
    else $error("regular accumulation lost a sample");
  AST_CLEAR_KEEP: assert property (!line_mode_i && clear_i && !sample_i |=>
    s.value == $past(s.value) - $past(clear_val_i))
    else $error("read clear left wrong residue");
  AST_LC_HOLD: assert property (line_mode_i && !interval_end_i && !clear_i |=>
    $stable(s.value))
    else $error("line-cycle register moved inside the interval");
endmodule // eamc_accum
`default_nettype wire

// *** hw/eamc_top.sv ***
// accumulation mode control: apb registers, wiring selection, energy
// registers, reverse power flags and frequency output accumulation
// assumes apb master on clk_i and power samples marked by sample_i
//
// Our own choices: the placing of the registers and the APB register port.
`timescale 1ns/10ps
`default_nettype none
`include "eamc_consts.svh"
module eamc_top #(
  parameter int PADDR_W = 20,
  parameter int VW = 16,
  parameter int EW = 32,
  parameter logic [15:0] LC_TARGET_RST = `EAMC_LCCNT_RST
)(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [PADDR_W-1:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [3:0] pstrb_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic sample_i,
  input wire logic [2:0][VW-1:0] volt_i,
  input wire logic [2:0][VW-1:0] curr_i,
  input wire logic [2:0][VW-1:0] curr_q_i,
  input wire logic [2:0][VW-1:0] vrms_i,
  input wire logic [2:0][VW-1:0] irms_i,
  input wire logic [VW-1:0] line_ac_rms_i,
  input wire logic [VW-1:0] wye2_b_rms_i,
  input wire logic [2:0][EW-1:0] fund_active_i,
  input wire logic [2:0][EW-1:0] fund_reactive_i,
  input wire logic [2:0] zx_i,
  output logic [VW-1:0] phase_b_voltage_rms_o,
  output logic [2:0] rev_active_flag_o,
  output logic [2:0] rev_reactive_flag_o,
  output logic [1:0] pulse_freq_output_o,
  output logic line_cycle_end_o
);
  import eamc_pkg::*;
  localparam int NK = 5;
  localparam int ACW = EW + 3;

  typedef struct packed {
    logic [7:0] accm;
    logic [7:0] lcyc;
    logic [15:0] flags;
    logic [2:0] terms;
    logic [15:0] lc_target;
    logic [15:0] zx_cnt;
    logic lc_end;
    logic [1:0][ACW-1:0] cf_acc;
    logic [1:0] cf_pulse;
    logic [31:0] prdata;
    logic slverr;
    logic [VW-1:0] vb_rms;
  } eamc_state_t;
  eamc_state_t s, n;

  eamc_connection_select_t connection_select;
  eamc_reactive_accum_mode_t reactive_accum_mode;
  logic rev_active_src_sel, rev_reactive_src_sel, read_clear_en;
  logic [2:0] zero_cross_phase_sel;
  logic [NK-1:0] line_mode;
  logic signed [VW:0] vb_eff;
  logic [VW-1:0] vb_rms_eff, vb_rms_reg;
  logic signed [VW:0] vsel [3];
  logic [VW:0] rsel [3];
  logic [EW-1:0] pw [NK][3];
  logic [EW-1:0] energy [NK][3];
  logic [NK-1:0][2:0] rclr;
  logic signed [EW:0] cft [2][3];
  logic [17:0] idx;
  logic setup, rd_acc, wr_acc, ehit, hit;
  logic [4:0] eslot;
  logic [31:0] rd_data;
  logic [15:0] w1c, fset;
  logic [1:0] zx_hits;
  logic [16:0] cnt_sum;
  logic signed [ACW-1:0] cf_sum [2];
  logic signed [ACW-1:0] cf_new [2];

  // sign-extend a sample by one bit
  function automatic logic signed [VW:0] sext(input logic [VW-1:0] v);
    return $signed({v[VW-1], v});
  endfunction

  // product cut to energy width; wrap-around is the software's concern
  function automatic logic [EW-1:0] mulp(input logic signed [VW:0] a,
                                         input logic signed [VW:0] b);
    logic signed [2*VW+1:0] p;
    p = a * b;
    return p[EW-1:0];
  endfunction

  // reactive contribution toward a frequency output
  function automatic logic signed [EW:0] cf_term(input logic [EW-1:0] q,
                                                 input logic [EW-1:0] p,
                                                 input eamc_reactive_accum_mode_t m);
    logic signed [EW:0] qs;
    qs = $signed({q[EW-1], q});
    unique case (m)
      EAMC_VAR_ABS: cf_term = q[EW-1] ? -qs : qs;
      EAMC_VAR_BY_ACT: cf_term = p[EW-1] ? -qs : qs;
      default: cf_term = qs;
    endcase
  endfunction

  // energy register decode, used by the read mux and the read clear
  function automatic logic energy_hit(input logic [17:0] a);
    return (a >= `EAMC_IDX_ENERGY) && (a < `EAMC_IDX_ENERGY + 18'(`EAMC_NUM_ENERGY));
  endfunction

  // configuration fields
  assign connection_select = eamc_connection_select_t'(s.accm[`EAMC_CONNECTION_SELECT_LO +: 2]);
  assign reactive_accum_mode = eamc_reactive_accum_mode_t'(s.accm[`EAMC_REACTIVE_ACCUM_MODE_LO +: 2]);
  assign rev_active_src_sel = s.accm[`EAMC_REVAP_BIT];
  assign rev_reactive_src_sel = s.accm[`EAMC_REVRP_BIT];
  assign read_clear_en = s.lcyc[`EAMC_READ_CLEAR_EN_BIT];
  assign zero_cross_phase_sel = s.lcyc[`EAMC_ZX_LO +: 3];
  assign line_mode[0] = s.lcyc[`EAMC_ACTIVE_LINE_CYCLE_EN_BIT];
  assign line_mode[1] = s.lcyc[`EAMC_REACTIVE_LINE_CYCLE_EN_BIT];
  assign line_mode[2] = s.lcyc[`EAMC_LVA_BIT];
  assign line_mode[3] = s.lcyc[`EAMC_ACTIVE_LINE_CYCLE_EN_BIT];
  assign line_mode[4] = 1'b0; // fundamental var-hour stays regular

  eamc_wiring #(
    .VW(VW)
  ) u_wiring (
    .connection_select_i(connection_select),
    .va_i(volt_i[0]),
    .vb_i(volt_i[1]),
    .vc_i(volt_i[2]),
    .va_rms_i(vrms_i[0]),
    .vb_rms_i(vrms_i[1]),
    .line_ac_rms_i(line_ac_rms_i),
    .wye2_b_rms_i(wye2_b_rms_i),
    .vb_eff_o(vb_eff),
    .vb_rms_eff_o(vb_rms_eff),
    .vb_rms_reg_o(vb_rms_reg)
  );

  // per-phase powers; only phase b sees the derived voltage
  always_comb
  begin
    for (int p = 0; p < 3; p++)
    begin
      vsel[p] = (p == 1) ? vb_eff : sext(volt_i[p]);
      rsel[p] = (p == 1) ? {1'b0, vb_rms_eff} : {1'b0, vrms_i[p]};
      pw[0][p] = mulp(vsel[p], sext(curr_i[p]));
      pw[1][p] = mulp(vsel[p], sext(curr_q_i[p]));
      pw[2][p] = mulp($signed(rsel[p]), $signed({1'b0, irms_i[p]}));
      pw[3][p] = fund_active_i[p];
      pw[4][p] = fund_reactive_i[p];
      cft[0][p] = cf_term(pw[1][p], pw[0][p], reactive_accum_mode);
      cft[1][p] = cf_term(pw[4][p], pw[3][p], reactive_accum_mode);
    end
  end

  // energy registers always accumulate signed powers
  for (genvar k = 0; k < NK; k++)
  begin : g_kind
    for (genvar p = 0; p < 3; p++)
    begin : g_phase
      eamc_accum #(
        .EW(EW)
      ) u_acc (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .sample_i(sample_i),
        .power_i(pw[k][p]),
        .line_mode_i(line_mode[k]),
        .interval_end_i(s.lc_end),
        .clear_i(rclr[k][p]),
        .clear_val_i(s.prdata),
        .value_o(energy[k][p])
      );
    end
  end

  // apb decode
  assign idx = 18'(paddr_i >> 2);
  assign setup = psel_i && !penable_i;
  assign rd_acc = psel_i && penable_i && !pwrite_i;
  assign wr_acc = psel_i && penable_i && pwrite_i && !s.slverr;
  assign ehit = energy_hit(idx);
  assign eslot = 5'(idx - `EAMC_IDX_ENERGY);

  // read mux, sampled into prdata at the setup edge
  always_comb
  begin
    rd_data = '0;
    hit = 1'b1;
    rclr = '0;
    unique case (idx)
      `EAMC_IDX_ACCUMULATION_MODE_CONFIG: rd_data[7:0] = s.accm;
      `EAMC_IDX_LCYC: rd_data[7:0] = s.lcyc & `EAMC_LCYC_MASK;
      `EAMC_IDX_TERMS: rd_data[2:0] = s.terms;
      `EAMC_IDX_LCCNT: rd_data[15:0] = s.lc_target;
      `EAMC_IDX_FLAGS: rd_data[15:0] = s.flags;
      default: hit = ehit;
    endcase
    for (int k = 0; k < NK; k++)
    begin
      for (int p = 0; p < 3; p++)
      begin
        if (ehit && eslot == 5'(k * 3 + p))
        begin
          rd_data = energy[k][p];
          rclr[k][p] = rd_acc && read_clear_en;
        end
      end
    end
  end

  // flag set and write-one-to-clear terms
  always_comb
  begin
    w1c = '0;
    if (wr_acc && idx == `EAMC_IDX_FLAGS)
      w1c = pwdata_i[15:0] & {{8{pstrb_i[1]}}, {8{pstrb_i[0]}}};
    fset = '0;
    for (int p = 0; p < 3; p++)
    begin
      fset[`EAMC_FLAG_REVAP_LO + p] = sample_i &&
        (rev_active_src_sel ? pw[3][p][EW-1] : pw[0][p][EW-1]);
      fset[`EAMC_FLAG_REVRP_LO + p] = sample_i &&
        (rev_reactive_src_sel ? pw[4][p][EW-1] : pw[1][p][EW-1]);
    end
  end

  // frequency output sums over the enabled phase terms
  always_comb
  begin
    for (int c = 0; c < 2; c++)
    begin
      cf_sum[c] = '0;
      for (int p = 0; p < 3; p++)
      begin
        if (s.terms[p] && sample_i)
          cf_sum[c] = cf_sum[c] + ACW'(cft[c][p]);
      end
      cf_new[c] = $signed(s.cf_acc[c]) + cf_sum[c];
    end
  end

  // zero crossings of the selected phases, several per cycle possible
  always_comb
  begin
    zx_hits = 2'(zx_i[0] & zero_cross_phase_sel[0]) +
              2'(zx_i[1] & zero_cross_phase_sel[1]) +
              2'(zx_i[2] & zero_cross_phase_sel[2]);
    cnt_sum = {1'b0, s.zx_cnt} + 17'(zx_hits);
  end

  // next state
  always_comb
  begin
    n = s;
    n.lc_end = 1'b0;
    n.cf_pulse = '0;
    n.vb_rms = vb_rms_reg;
    if (setup)
    begin
      n.prdata = rd_data;
      n.slverr = !hit;
    end
    if (wr_acc && pstrb_i[0])
    begin
      unique case (idx)
        `EAMC_IDX_ACCUMULATION_MODE_CONFIG: n.accm = pwdata_i[7:0];
        `EAMC_IDX_LCYC: n.lcyc = pwdata_i[7:0] & `EAMC_LCYC_MASK;
        `EAMC_IDX_TERMS: n.terms = pwdata_i[2:0];
        `EAMC_IDX_LCCNT: n.lc_target[7:0] = pwdata_i[7:0];
        default: ;
      endcase
    end
    if (wr_acc && pstrb_i[1] && idx == `EAMC_IDX_LCCNT)
      n.lc_target[15:8] = pwdata_i[15:8];
    // a new event beats a clear in the same cycle
    n.flags = ((s.flags & ~w1c) | fset) & `EAMC_FLAG_MASK;
    // interval restarts from zero; idle while no line-cycle enable
    if (|s.lcyc[2:0])
    begin
      if (zx_hits != 2'h0 && cnt_sum >= {1'b0, s.lc_target})
      begin
        n.lc_end = 1'b1;
        n.zx_cnt = '0;
      end
      else
        n.zx_cnt = cnt_sum[15:0];
    end
    else
      n.zx_cnt = '0;
    // one pulse per threshold of energy, either sign
    for (int c = 0; c < 2; c++)
    begin
      n.cf_acc[c] = cf_new[c];
      if (cf_new[c] >= $signed(`EAMC_CF_THRESH))
      begin
        n.cf_acc[c] = cf_new[c] - $signed(`EAMC_CF_THRESH);
        n.cf_pulse[c] = 1'b1;
      end
      else if (cf_new[c] <= -$signed(`EAMC_CF_THRESH))
      begin
        n.cf_acc[c] = cf_new[c] + $signed(`EAMC_CF_THRESH);
        n.cf_pulse[c] = 1'b1;
      end
    end
  end

  // state register
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      s <= '0;
      s.accm <= `EAMC_ACCM_RST;
      s.lcyc <= `EAMC_LCYC_RST;
      s.terms <= `EAMC_TERMS_RST;
      s.lc_target <= LC_TARGET_RST;
    end
    else
      s <= n;
  end

  // outputs; pready is combinational, one access cycle per transfer
  assign pready_o = psel_i && penable_i;
  assign prdata_o = s.prdata;
  assign pslverr_o = s.slverr;
  assign phase_b_voltage_rms_o = s.vb_rms;
  assign rev_active_flag_o = s.flags[`EAMC_FLAG_REVAP_LO +: 3];
  assign rev_reactive_flag_o = s.flags[`EAMC_FLAG_REVRP_LO +: 3];
  assign pulse_freq_output_o = s.cf_pulse;
  assign line_cycle_end_o = s.lc_end;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_rd_setup;
    psel_i && !penable_i && !pwrite_i;
  endsequence
  sequence s_access;
    psel_i && penable_i;
  endsequence

  AST_WYE3_B: assert property (connection_select == EAMC_WYE3 |->
    vb_eff == sext(volt_i[1]))
    else $error("wye3 phase b voltage wrong");
  AST_WYE2_B: assert property (connection_select == EAMC_WYE2 |->
    vb_eff == -sext(volt_i[0]) - sext(volt_i[2]))
    else $error("wye2 phase b voltage wrong");
  AST_DELTA4_B: assert property (connection_select == EAMC_DELTA4 |->
    vb_eff == -sext(volt_i[0]))
    else $error("delta4 phase b voltage wrong");
  AST_DELTA3_RMS: assert property (connection_select == EAMC_DELTA3 |=>
    phase_b_voltage_rms_o == $past(line_ac_rms_i))
    else $error("delta3 line rms not in phase b rms");
  AST_REV_ACT: assert property (!rev_active_src_sel && sample_i && pw[0][0][EW-1] |=>
    rev_active_flag_o[0])
    else $error("total active reversal not flagged");
  AST_REV_REACT_FUND: assert property (rev_reactive_src_sel && sample_i &&
    fund_reactive_i[1][EW-1] |=> rev_reactive_flag_o[1])
    else $error("fundamental reactive reversal not flagged");
  AST_CF_ABS: assert property (reactive_accum_mode == EAMC_VAR_ABS |->
    !cft[0][0][EW] && !cft[0][1][EW] && !cft[0][2][EW])
    else $error("absolute mode term negative");
  AST_CF_BY_ACT: assert property (reactive_accum_mode == EAMC_VAR_BY_ACT &&
    pw[0][2][EW-1] |-> cft[0][2] == -$signed({pw[1][2][EW-1], pw[1][2]}))
    else $error("reactive sign not reversed by negative active");
  AST_CF_SIGNED: assert property (reactive_accum_mode inside {EAMC_VAR_SIGNED,
    EAMC_VAR_RSVD} |-> cft[1][0] == $signed({pw[4][0][EW-1], pw[4][0]}))
    else $error("signed mode altered reactive term");
  AST_LC_RESTART: assert property (line_cycle_end_o |-> s.zx_cnt == 16'h0000 &&
    $past(|s.lcyc[2:0]) && $past(zx_hits != 2'h0))
    else $error("line-cycle interval ended without a crossing");
  AST_RSVD7: assert property (s_rd_setup ##1 (s_access and idx == `EAMC_IDX_LCYC) |->
    !prdata_o[7])
    else $error("reserved line-cycle bit read as one");
  AST_READ_CLEAR: assert property (rd_acc && ehit && read_clear_en |->
    rclr != '0)
    else $error("energy read with clear enabled did not clear");
endmodule // eamc_top
`default_nettype wire

// *** sim/tb_top.sv ***
// self-checking bench for the accumulation mode block
// assumes eamc_top answers apb with zero wait states on clk_i
`timescale 1ns/10ps
`default_nettype none
`include "eamc_consts.svh"
module tb_top;
  import eamc_pkg::*;
  localparam logic [17:0] AM = `EAMC_IDX_ACCUMULATION_MODE_CONFIG;
  localparam logic [17:0] LC = `EAMC_IDX_LCYC;
  localparam logic [17:0] FL = `EAMC_IDX_FLAGS;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic psel = 1'b0, pen = 1'b0, pwr = 1'b0, smp_s = 1'b0, pready, pslverr, lce, err, seen;
  logic [19:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic [2:0][15:0] volt = '0, curr = '0, cq = '0, vrms = '0, irms = '0;
  logic [15:0] lac = '0, w2 = '0, bvr;
  logic [2:0][31:0] fa = '0, fr = '0;
  logic [2:0] zx = '0, raf, rrf, ex;
  logic [1:0] cf, pulses;
  int errors = 0;
  int cmp_count = 0;

  // 25 ns period
  always #12.5 clk_i = ~clk_i;

  eamc_top dut (
    .clk_i(clk_i), .rst_i(rst_i), .psel_i(psel), .penable_i(pen), .pwrite_i(pwr),
    .paddr_i(paddr), .pwdata_i(pwdata), .pstrb_i(4'hf), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr), .sample_i(smp_s), .volt_i(volt),
    .curr_i(curr), .curr_q_i(cq), .vrms_i(vrms), .irms_i(irms), .line_ac_rms_i(lac),
    .wye2_b_rms_i(w2), .fund_active_i(fa), .fund_reactive_i(fr), .zx_i(zx),
    .phase_b_voltage_rms_o(bvr), .rev_active_flag_o(raf), .rev_reactive_flag_o(rrf),
    .pulse_freq_output_o(cf), .line_cycle_end_o(lce));

  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // one transfer; request held until pready is seen high at an edge
  // no wait-state limit here; only the watchdog ends a hung transfer
  task automatic apb(input logic w, input logic [17:0] idx, input logic [31:0] d);
    @(posedge clk_i);
    psel <= 1'b1;
    pwr <= w;
    paddr <= {idx, 2'b00};
    pwdata <= d;
    @(posedge clk_i);
    pen <= 1'b1;
    do
      @(posedge clk_i);
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask

  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e)
    begin
      errors++;
      $display("BAD %s expected %h seen %h", s, e, g);
    end
  endtask

  // one-cycle power sample strobe
  task automatic smp();
    @(posedge clk_i);
    smp_s <= 1'b1;
    @(posedge clk_i);
    smp_s <= 1'b0;
  endtask

  // crossing pulse, then watch three edges for the interval end
  task automatic zxp(input logic [2:0] v);
    @(posedge clk_i);
    zx <= v;
    @(posedge clk_i);
    zx <= 3'h0;
    seen = 1'b0;
    repeat (3)
    begin
      @(posedge clk_i);
      if (lce === 1'b1)
        seen = 1'b1;
    end
  endtask

  // one reactive sample on phase a, total and fundamental alike,
  // then collect the pulses that it launches
  task automatic cfs(input logic [15:0] q, input logic [15:0] c);
    cq <= {16'h0, 16'h0, q};
    curr <= {16'h0, 16'h0, c};
    fr <= {32'h0, 32'h0, mul(32'h200, q)};
    fa <= {32'h0, 32'h0, sx(c)};
    smp();
    @(posedge clk_i);
    pulses = pulses | cf;
  endtask

  function automatic logic [17:0] eidx(input int k, input int p);
    return `EAMC_IDX_ENERGY + 18'(k * 3 + p);
  endfunction

  function automatic logic [31:0] mul(input logic [31:0] x, input logic [15:0] y);
    logic signed [31:0] b;
    b = $signed(y);
    return $signed(x) * b;
  endfunction

  function automatic logic [31:0] sx(input logic [15:0] x);
    logic signed [31:0] a;
    a = $signed(x);
    return a;
  endfunction

  // phase b voltage as the wiring setting derives it
  function automatic logic [31:0] vbx(input int c);
    case (c)
      0: return sx(volt[1]);
      1: return sx(volt[0]) - sx(volt[2]);
      2: return -sx(volt[0]) - sx(volt[2]);
      default: return -sx(volt[0]);
    endcase
  endfunction

  function automatic logic [15:0] brms(input int c);
    case (c)
      0: return vrms[1];
      1: return lac;
      2: return w2;
      default: return vrms[0];
    endcase
  endfunction

  // hang guard, far above the few hundred cycles the tests need
  initial
  begin
    repeat (20000) @(posedge clk_i);
    errors++;
    end_sim();
  end

  initial
  begin
    void'($urandom(32'hd9d1));
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    apb(0, AM, 0);
    chk("accumulation_mode_config reset", 32'h0, rd);
    apb(0, LC, 0);
    chk("lcyc reset", 32'h78, rd);
    apb(1, LC, 32'hff);
    apb(0, LC, 0);
    chk("lcyc reserved bit", 32'h7f, rd);
    apb(0, 18'h00010, 0);
    chk("unmapped error", 32'h1, 32'(err));
    apb(1, LC, 32'h78);
    $display("test registers done");
    // registers stay signed in every reactive mode
    for (int i = 0; i < 16; i++)
    begin
      apb(1, AM, 32'(i % 4) << 2);
      volt[0] <= 16'($urandom);
      curr[0] <= 16'($urandom);
      cq[0] <= 16'($urandom);
      smp();
      apb(0, eidx(0, 0), 0);
      chk("active a", mul(sx(volt[0]), curr[0]), rd);
      apb(0, eidx(1, 0), 0);
      chk("reactive a", mul(sx(volt[0]), cq[0]), rd);
    end
    $display("test random accumulation done");
    for (int c = 0; c < 4; c++)
    begin
      apb(1, AM, 32'(c) << 4);
      apb(1, `EAMC_IDX_TERMS, (c == 1) ? 32'h5 : 32'h7);
      for (int p = 0; p < 3; p++)
      begin
        volt[p] <= 16'($urandom_range(4000)) - 16'd2000;
        curr[p] <= 16'($urandom_range(4000)) - 16'd2000;
        cq[p] <= 16'($urandom_range(4000)) - 16'd2000;
        vrms[p] <= 16'($urandom);
        irms[p] <= 16'($urandom);
      end
      lac <= 16'($urandom);
      w2 <= 16'($urandom);
      smp();
      apb(0, eidx(0, 1), 0);
      chk("active b", mul(vbx(c), curr[1]), rd);
      apb(0, eidx(1, 1), 0);
      chk("reactive b", mul(vbx(c), cq[1]), rd);
      apb(0, eidx(2, 1), 0);
      chk("apparent b", {16'h0, brms(c)} * {16'h0, irms[1]}, rd);
      chk("phase b rms", {16'h0, (c == 1) ? lac : vrms[1]}, {16'h0, bvr});
      apb(0, eidx(0, 1), 0);
      chk("cleared on read", 32'h0, rd);
    end
    apb(1, LC, 32'h38);
    smp();
    apb(0, eidx(0, 1), 0);
    apb(0, eidx(0, 1), 0);
    chk("kept on read", mul(vbx(3), curr[1]), rd);
    $display("test wiring done");
    apb(1, AM, 0);
    for (int s = 0; s < 2; s++)
    begin
      for (int p = 0; p < 2; p++)
      begin
        apb(1, AM, 32'(s * 8'hc0));
        apb(1, FL, 32'h1dc0);
        volt <= {3{16'd100}};
        curr <= {3{p ? 16'hfffb : 16'h0005}};
        cq <= {3{p ? 16'hfffb : 16'h0005}};
        fa <= {3{p ? 32'd1000 : 32'hfffffc18}};
        fr <= {3{p ? 32'd1000 : 32'hfffffc18}};
        smp();
        apb(0, FL, 0);
        ex = (s != p) ? 3'h7 : 3'h0;
        chk("active flags", 32'(ex), 32'(raf));
        chk("reactive flags", 32'(ex), 32'(rrf));
        chk("flag register", {19'h0, ex, 1'b0, ex, 6'h0}, rd & 32'h1dc0);
      end
    end
    $display("test reverse flags done");
    apb(1, `EAMC_IDX_LCCNT, 32'd2);
    apb(1, LC, 32'h09);
    zxp(3'b010);
    zxp(3'b010);
    chk("unselected phase", 32'h0, 32'(seen));
    zxp(3'b001);
    zxp(3'b001);
    chk("interval end", 32'h1, 32'(seen));
    apb(1, LC, 32'h19);
    zxp(3'b011);
    chk("two phases", 32'h1, 32'(seen));
    $display("test line cycle done");
    // mid-run reset clears the pulse residues, so each mode starts at zero
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    apb(0, AM, 0);
    chk("accumulation_mode_config after reset", 32'h0, rd);
    volt <= {16'h0, 16'h0, 16'h0200};
    // half a threshold each: +q then -q with active turning negative
    for (int m = 0; m < 4; m++)
    begin
      apb(1, AM, 32'(m) << 2);
      pulses = 2'b00;
      cfs(16'h0400, 16'h0001);
      cfs(16'hfc00, 16'hffff);
      chk("freq pulses", {30'h0, {2{m >= 2}}}, {30'h0, pulses});
    end
    $display("test frequency outputs done");
    end_sim();
  end
endmodule // tb_top
`default_nettype wire
